// ==== bench/sid_diag_top_tb.sv ====
// Self-checking bench for the safe input diagnostics block
`timescale 1ns/100ps
module sid_diag_top_tb;
  import sid_pkg::*;
  localparam int LIMIT = 8000;
  logic                mclk = 1'b0;
  logic                resetn = 1'b0;
  logic [N_IN-1:0]     ch_a, ch_b, thr_ok, safe_in;
  logic [N_IN-1:0]     closed = '1, fed = '0, sel = '0, stuck = '0, xs_en = '0;
  logic [N_PAIR-1:0]   pair_en = '0, tmon_en = '0;
  logic                thr_bad = 1'b0, thr_test, low_test, alarm;
  logic [N_PULSE-1:0]  pulse;
  logic [N_CAUSE-1:0]  cause;
  int                  mismatches = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;

  // ****************************************
  // Clock, instances, timeout
  // ****************************************
  always #2.5 mclk = ~mclk;

  sid_diag_top #(.DISC_CYC(50), .TEST_PERIOD(100), .SLOT_CYC(8)) i_sid_diag_top (
    .MCLK(mclk), .RESETN(resetn), .CH_A_IN(ch_a), .CH_B_IN(ch_b),
    .THR_OK_A(thr_ok), .THR_OK_B(thr_ok), .XS_EN(xs_en), .XS_SEL(sel),
    .PAIR_EN(pair_en), .TIME_MON_EN(tmon_en), .THR_TEST(thr_test),
    .LOW_TEST(low_test), .PULSE_OUT(pulse), .SAFE_IN(safe_in), .ALARM(alarm),
    .ALARM_CAUSE(cause));

  sid_sensor_model i_sid_sensor_model (
    .pulse(pulse), .low_test(low_test), .closed(closed), .fed(fed), .sel(sel),
    .stuck(stuck), .thr_bad(thr_bad), .ch_a(ch_a), .ch_b(ch_b), .thr_ok(thr_ok));

  // Bounded so a stuck scheduler cannot hang the run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk_lvl(input string what, input logic [N_IN-1:0] exp);
    @(negedge mclk);
    samples_checked++;
    if (safe_in !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, safe_in);
    end
    // Hand back at a rising edge so the next stimulus lands there
    @(posedge mclk);
  endtask

  task automatic chk_st(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flags(input logic [4:0] exp);
    @(negedge mclk);
    chk_st("alarm", {3'h0, exp}, {3'h0, alarm, cause});
    @(posedge mclk);
  endtask

  // Static configuration only changes while reset is held
  task automatic restart(input logic [N_IN-1:0] x, input logic [N_PAIR-1:0] p, t);
    @(posedge mclk);
    resetn <= 1'b0;
    xs_en <= x;
    fed <= x;
    sel <= 14'h2AAA;
    pair_en <= p;
    tmon_en <= t;
    stuck <= '0;
    thr_bad <= 1'b0;
    tick(16);
    resetn <= 1'b1;
    tick(4);
  endtask

  task automatic cycle_low();
    closed <= '0;
    tick(20);
    closed <= '1;
    tick(6);
  endtask

  task automatic wait_thr();
    int n;
    n = 0;
    while (thr_test !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [2:0] seen;
    restart('0, 7'h40, '0);
    tick(20);
    chk_lvl("no start test", '0);
    cycle_low();
    closed <= 14'h3FEF;
    stuck <= 14'h0010;
    tick(200);
    chk_lvl("disagree", 14'h3FEF);
    chk_flags(5'h00);
    wait_thr();
    repeat (16) @(negedge mclk);
    chk_st("tests", 8'h01, {6'h0, thr_test, low_test});
    repeat (16) @(negedge mclk);
    chk_st("tests", 8'h00, {6'h0, thr_test, low_test});
    @(posedge mclk);
    closed[13] <= 1'b0;
    tick(200);
    chk_lvl("pair", 14'h0FEF);
    chk_flags(5'h00);
    restart('0, '0, '0);
    cycle_low();
    stuck <= 14'h0001;
    tick(200);
    chk_flags(5'h12);
    chk_lvl("low fail", '0);
    restart('0, '0, '0);
    cycle_low();
    thr_bad <= 1'b1;
    tick(200);
    chk_flags(5'h11);
    chk_lvl("thr fail", '0);
    restart('1, '0, '0);
    cycle_low();
    seen = '0;
    repeat (128) begin
      @(negedge mclk);
      seen = seen | {pulse == 2'b10, pulse == 2'b01, pulse == 2'b00};
    end
    chk_st("pulses", 8'h06, {5'h0, seen});
    tick(300);
    chk_lvl("signed", 14'h3FFF);
    chk_flags(5'h00);
    fed[3] <= 1'b0;
    tick(300);
    chk_flags(5'h14);
    chk_lvl("short", '0);
    restart('0, 7'h01, 7'h01);
    cycle_low();
    wait_thr();
    tick(53);
    repeat (2) begin
      closed[1] <= 1'b0;
      tick(30);
      closed[1] <= 1'b1;
      tick(10);
    end
    chk_flags(5'h00);
    closed[1] <= 1'b0;
    tick(200);
    chk_flags(5'h18);
    stop_test();
  end
endmodule // sid_diag_top_tb

// ==== bench/sid_sensor_model.sv ====
// Sensor contacts and wiring on the input terminals
`timescale 1ns/100ps
module sid_sensor_model (
  // Pulse lines and low test strobe
  input  wire logic [sid_pkg::N_PULSE-1:0] pulse,
  input  wire logic                        low_test,
  // Contact states and wiring faults
  input  wire logic [sid_pkg::N_IN-1:0]    closed,
  input  wire logic [sid_pkg::N_IN-1:0]    fed,
  input  wire logic [sid_pkg::N_IN-1:0]    sel,
  input  wire logic [sid_pkg::N_IN-1:0]    stuck,
  input  wire logic                        thr_bad,
  // Channel readings
  output logic [sid_pkg::N_IN-1:0]         ch_a,
  output logic [sid_pkg::N_IN-1:0]         ch_b,
  output logic [sid_pkg::N_IN-1:0]         thr_ok
);
  import sid_pkg::*;
  logic [N_IN-1:0] lvl;
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      // A fed contact only carries the level of its own pulse line
      lvl[i] = closed[i] & (fed[i] ? pulse[sel[i]] : 1'b1);
    end
  end
  // Low test pulls both channels down; a short to High keeps channel A up
  assign ch_a   = stuck | (lvl & {N_IN{~low_test}});
  assign ch_b   = lvl & {N_IN{~low_test}};
  assign thr_ok = {N_IN{~thr_bad}};
endmodule // sid_sensor_model

// ==== rtl/sid_diag_top.sv ====
// Diagnostic evaluation of dual-channel safety inputs
`timescale 1ns/100ps

// Contract
// - Input High only when both channels read High; disagreement gives Low.
// - Cyclically test High thresholds of each channel; alarm on failure.
// - Cyclically test switching to Low, skipping the exempt inputs; alarm on failure.
// - Drive pulse outputs, each with its own distinct signature.
// - Contacts fed from assigned pulse; High must carry that pulse signature.
// - High input without matching signature is flagged as short or cross-short.
// - Multi-contact sensor High only when all contacts are satisfied.
// - Two closed-type contacts: High only while both are closed.
// - Closed plus open type: High only when open one actuated, closed one not.
// - With time monitoring, contacts must agree within 0.5 s, else alarm.
// - Signature and time monitoring only when configured; other tests always run.
module sid_diag_top #(
  parameter int DISC_CYC    = sid_pkg::DISC_CYCLES,
  parameter int TEST_PERIOD = sid_pkg::TEST_PERIOD_CYC,
  parameter int SLOT_CYC    = sid_pkg::SLOT_CYC
) (
  // Clock and reset
  input  wire logic                        MCLK,
  input  wire logic                        RESETN,
  // Channel readings from the input terminals
  input  wire logic [sid_pkg::N_IN-1:0]    CH_A_IN,
  input  wire logic [sid_pkg::N_IN-1:0]    CH_B_IN,
  // Threshold comparator results during a threshold test
  input  wire logic [sid_pkg::N_IN-1:0]    THR_OK_A,
  input  wire logic [sid_pkg::N_IN-1:0]    THR_OK_B,
  // Configuration
  input  wire logic [sid_pkg::N_IN-1:0]    XS_EN,
  input  wire logic [sid_pkg::N_IN-1:0]    XS_SEL,
  input  wire logic [sid_pkg::N_PAIR-1:0]  PAIR_EN,
  input  wire logic [sid_pkg::N_PAIR-1:0]  TIME_MON_EN,
  // Test stimulus and pulse lines
  output logic                             THR_TEST,
  output logic                             LOW_TEST,
  output logic [sid_pkg::N_PULSE-1:0]      PULSE_OUT,
  // Results
  output logic [sid_pkg::N_IN-1:0]         SAFE_IN,
  output logic                             ALARM,
  output logic [sid_pkg::N_CAUSE-1:0]      ALARM_CAUSE
);
  import sid_pkg::*;
  localparam int               TW        = $clog2(TEST_PERIOD);
  localparam logic [TW-1:0]    PER_LAST  = TW'(TEST_PERIOD - 1);
  localparam logic [TW-1:0]    LEN_LAST  = TW'(TEST_LEN_CYC - 1);
  localparam int               DW        = $clog2(DISC_CYC + 1);
  localparam logic [DW-1:0]    DISC_LAST = DW'(DISC_CYC - 1);
  localparam logic [N_IN-1:0]  ALL_ONES  = '1;
  // Two contacts of pair p, used for both the AND and the agreement check
  function automatic logic [1:0] pair_bits(input logic [N_IN-1:0] v, input int p);
    pair_bits = {v[2*p+1], v[2*p]};
  endfunction

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0]      rs_q, vld_q;
  logic            rst_n;
  logic [N_IN-1:0] a_m_q, a_s, b_m_q, b_s, ta_m_q, ta_s, tb_m_q, tb_s;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];
  // Synchroniser zeros after reset are no reading; vld_q marks a filled pipe
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      {a_m_q, a_s, b_m_q, b_s}     <= '0;
      {ta_m_q, ta_s, tb_m_q, tb_s, vld_q} <= '0;
    end else begin
      vld_q  <= {vld_q[0], 1'b1};
      a_m_q  <= CH_A_IN;
      a_s    <= a_m_q;
      b_m_q  <= CH_B_IN;
      b_s    <= b_m_q;
      ta_m_q <= THR_OK_A;
      ta_s   <= ta_m_q;
      tb_m_q <= THR_OK_B;
      tb_s   <= tb_m_q;
    end
  end

  // ****************************************
  // Signature generator
  // ****************************************
  logic [N_PULSE-1:0] pulse_w;
  logic               slot_end;
  sid_sig_gen #(.SLOT_CYC(SLOT_CYC)) u_sig (
    .clk        (MCLK),
    .rst_n      (rst_n),
    .pulse_o    (pulse_w),
    .slot_end_o (slot_end)
  );
  assign PULSE_OUT = pulse_w;

  // ****************************************
  // Cyclic test scheduler
  // ****************************************
  sid_test_t     st_q, st_d;
  logic [TW-1:0] tcnt_q, tcnt_d;
  logic          thr_fail, low_fail, thr_d, low_d, frozen;
  always_comb begin
    st_d     = st_q;
    tcnt_d   = tcnt_q + 1'b1;
    thr_fail = 1'b0;
    low_fail = 1'b0;
    unique case (st_q)
      ST_IDLE: if (tcnt_q == PER_LAST) begin
        st_d   = ST_THR;
        tcnt_d = '0;
      end
      ST_THR: if (tcnt_q == LEN_LAST) begin
        thr_fail = (ta_s & tb_s) != ALL_ONES;
        st_d     = ST_LOW;
        tcnt_d   = '0;
      end
      ST_LOW: if (tcnt_q == LEN_LAST) begin
        low_fail = ((a_s | b_s) & ~LOW_TEST_EXEMPT_INPUTS) != '0;
        st_d     = ST_RECOV;
        tcnt_d   = '0;
      end
      ST_RECOV: if (tcnt_q == LEN_LAST) begin
        st_d   = ST_IDLE;
        tcnt_d = '0;
      end
    endcase
    thr_d = (st_d == ST_THR);
    low_d = (st_d == ST_LOW);
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= ST_IDLE;
      tcnt_q   <= '0;
      THR_TEST <= 1'b0;
      LOW_TEST <= 1'b0;
    end else begin
      st_q     <= st_d;
      tcnt_q   <= tcnt_d;
      THR_TEST <= thr_d;
      LOW_TEST <= low_d;
    end
  end
  // Levels are held during tests and the settle time after them
  assign frozen = (st_q != ST_IDLE);
  // ****************************************
  // Channel evaluation and signature check
  // ****************************************
  logic [N_IN-1:0] lvl_q, lvl_d, arm_q, arm_d, both, psel, mism, upd;
  logic            xs_fail;
  always_comb begin
    both    = a_s & b_s;
    lvl_d   = lvl_q;
    psel    = '0;
    xs_fail = 1'b0;
    upd     = '0;
    for (int i = 0; i < N_IN; i++) begin
      psel[i] = pulse_w[XS_SEL[i]];
      if (!frozen) begin
        if (!XS_EN[i]) begin
          lvl_d[i] = both[i];
          upd[i]   = 1'b1;
        end else if (slot_end) begin
          if (psel[i]) begin
            lvl_d[i] = both[i];
            upd[i]   = 1'b1;
          end else if (both[i]) begin
            xs_fail = 1'b1;
          end
        end
      end
    end
    // Armed only by a Low read from the pins; reset zeros and test windows do not count
    arm_d = arm_q | (upd & ~both & {N_IN{vld_q[1]}});
  end
  assign mism = (a_s ^ b_s) & ~XS_EN;
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= '0;
      arm_q <= '0;
    end else begin
      lvl_q <= lvl_d;
      arm_q <= arm_d;
    end
  end
  // ****************************************
  // Multi-contact sensors and discrepancy timing
  // ****************************************
  logic [DW-1:0]     dcnt_q [N_PAIR];
  logic [DW-1:0]     dcnt_d [N_PAIR];
  logic [N_PAIR-1:0] agree;
  logic              disc_fail;
  always_comb begin
    disc_fail = 1'b0;
    for (int p = 0; p < N_PAIR; p++) begin
      agree[p] = ^pair_bits(lvl_q, p) == 1'b0;
      if (!PAIR_EN[p] || !TIME_MON_EN[p] || agree[p]) begin
        dcnt_d[p] = '0;
      end else if (dcnt_q[p] != DISC_LAST) begin
        dcnt_d[p] = dcnt_q[p] + 1'b1;
      end else begin
        dcnt_d[p] = dcnt_q[p];
      end
      if (dcnt_q[p] == DISC_LAST) begin
        disc_fail = 1'b1;
      end
    end
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < N_PAIR; p++) begin
        dcnt_q[p] <= '0;
      end
    end else begin
      dcnt_q <= dcnt_d;
    end
  end
  // ****************************************
  // Alarm latch and results
  // ****************************************
  logic [N_CAUSE-1:0] cause_d;
  logic [N_IN-1:0]    sens, safe_d;
  logic               alarm_d;
  always_comb begin
    cause_d = ALARM_CAUSE;
    cause_d[CAUSE_THR]  = ALARM_CAUSE[CAUSE_THR] | thr_fail;
    cause_d[CAUSE_LOW]  = ALARM_CAUSE[CAUSE_LOW] | low_fail;
    cause_d[CAUSE_XS]   = ALARM_CAUSE[CAUSE_XS] | xs_fail;
    cause_d[CAUSE_DISC] = ALARM_CAUSE[CAUSE_DISC] | disc_fail;
    alarm_d = ALARM | (cause_d != '0);
    sens    = lvl_q & arm_q;
    for (int p = 0; p < N_PAIR; p++) begin
      // Open-type contacts close when actuated, so every contact reads High when satisfied
      if (PAIR_EN[p]) begin
        {sens[2*p+1], sens[2*p]} = {2{&pair_bits(lvl_q & arm_q, p)}};
      end
    end
    safe_d = alarm_d ? '0 : sens;
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ALARM_CAUSE <= '0;
      ALARM       <= 1'b0;
      SAFE_IN     <= '0;
    end else begin
      ALARM_CAUSE <= cause_d;
      ALARM       <= alarm_d;
      SAFE_IN     <= safe_d;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);
  sequence s_thr_end;
    st_q == ST_THR && tcnt_q == LEN_LAST;
  endsequence
  sequence s_low_end;
    st_q == ST_LOW && tcnt_q == LEN_LAST;
  endsequence
  a_cross_cmp: assert property (!frozen && mism != '0 |=> (lvl_q & $past(mism)) == '0)
    else $error("disagreeing channels left an input High");
  a_thr_alarm: assert property (s_thr_end ##0 (ta_s & tb_s) != ALL_ONES
    |=> ALARM && ALARM_CAUSE[CAUSE_THR] && st_q == ST_LOW)
    else $error("threshold failure did not raise the alarm");
  a_low_alarm: assert property (s_low_end ##0 ((a_s | b_s) & ~LOW_TEST_EXEMPT_INPUTS) != '0
    |=> ALARM && ALARM_CAUSE[CAUSE_LOW])
    else $error("low switching failure did not raise the alarm");
  a_xs_fault: assert property (slot_end && !frozen && (both & XS_EN & ~psel) != '0
    |=> ALARM_CAUSE[CAUSE_XS] ##1 SAFE_IN == '0)
    else $error("signature mismatch not flagged");
  a_xs_gated: assert property ($rose(ALARM_CAUSE[CAUSE_XS]) |-> $past(XS_EN) != '0)
    else $error("signature alarm without signature checking enabled");
  a_pair_and: assert property (PAIR_EN[0] && !ALARM && $past(PAIR_EN[0]) && SAFE_IN[0]
    |-> $past(lvl_q[0]) && $past(lvl_q[1]) && SAFE_IN[1])
    else $error("paired sensor High without both contacts");
  a_disc_alarm: assert property (dcnt_q[0] == DISC_LAST |=> ALARM && ALARM_CAUSE[CAUSE_DISC])
    else $error("discrepancy timeout without alarm");
  a_disc_restart: assert property (agree[0] |=> dcnt_q[0] == '0)
    else $error("discrepancy counter not restarted");
  a_alarm_hold: assert property (ALARM |=> ALARM ##1 (SAFE_IN == '0) [*2])
    else $error("alarm released or inputs not forced Low");
  a_start_test: assert property (SAFE_IN[0] |-> $past(arm_q[0]))
    else $error("input High before its first Low since reset");

endmodule // sid_diag_top

// ==== rtl/sid_pkg.sv ====
// Shared constants and types for the safe input diagnostics block
package sid_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int N_IN    = 14;
  localparam int N_PAIR  = 7;
  localparam int N_PULSE = 2;
  localparam int N_SLOT  = 8;
  localparam int SLOT_W  = 3;

  // Inputs that the low switchability test leaves out (fifth to eighth)
  localparam logic [N_IN-1:0] LOW_TEST_EXEMPT_INPUTS = 14'h00F0;

  // Pulse signatures, one bit per slot; each pulse drops low in its own slot
  localparam logic [N_SLOT-1:0] SIG_PULSE0 = 8'hFE;
  localparam logic [N_SLOT-1:0] SIG_PULSE1 = 8'hEF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ         = 200;
  localparam int DISC_TIME_MS    = 500;
  localparam int DISC_CYCLES     = DISC_TIME_MS * 1000 * CLK_MHZ;
  localparam int TEST_PERIOD_US  = 10;
  localparam int TEST_PERIOD_CYC = TEST_PERIOD_US * CLK_MHZ;
  localparam int TEST_LEN_CYC    = 16;
  localparam int SLOT_CYC        = 40;

  // ****************************************
  // Alarm cause bits
  // ****************************************
  localparam int N_CAUSE    = 4;
  localparam int CAUSE_THR  = 0;
  localparam int CAUSE_LOW  = 1;
  localparam int CAUSE_XS   = 2;
  localparam int CAUSE_DISC = 3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_THR   = 4'h2,
    ST_LOW   = 4'h4,
    ST_RECOV = 4'h8
  } sid_test_t;

endpackage

// ==== rtl/sid_sig_gen.sv ====
// Pulse output signature generator
`timescale 1ns/100ps
module sid_sig_gen #(
  parameter int SLOT_CYC = sid_pkg::SLOT_CYC
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Pulse lines and slot timing
  output logic [sid_pkg::N_PULSE-1:0]      pulse_o,
  output logic                             slot_end_o
);
  import sid_pkg::*;

  localparam int              CW        = $clog2(SLOT_CYC);
  localparam logic [CW-1:0]   SLOT_LAST = CW'(SLOT_CYC - 1);
  localparam logic [SLOT_W-1:0] SLOT_TOP = SLOT_W'(N_SLOT - 1);

  logic [CW-1:0]       cnt_q, cnt_d;
  logic [SLOT_W-1:0]   slot_q, slot_d;
  logic [N_PULSE-1:0]  pulse_d;
  logic                end_d;

  // ****************************************
  // Slot sequencer
  // ****************************************
  always_comb begin
    cnt_d  = (cnt_q == SLOT_LAST) ? '0 : cnt_q + 1'b1;
    slot_d = (cnt_q == SLOT_LAST) ? slot_q + 1'b1 : slot_q;
    // Distinct patterns let a High input be traced to its pulse line
    pulse_d = {SIG_PULSE1[slot_d], SIG_PULSE0[slot_d]};
    end_d   = (cnt_d == SLOT_LAST);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= '0;
      slot_q     <= '0;
      pulse_o    <= {SIG_PULSE1[0], SIG_PULSE0[0]};
      slot_end_o <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      slot_q     <= slot_d;
      pulse_o    <= pulse_d;
      slot_end_o <= end_d;
    end
  end

  a_sig_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    slot_end_o && slot_q == SLOT_TOP |=> slot_q == '0 && pulse_o == {SIG_PULSE1[0], SIG_PULSE0[0]})
    else $error("signature frame did not restart at slot zero");

  a_sig_differ: assert property (@(posedge clk) disable iff (!rst_n)
    pulse_o[0] != pulse_o[1] |-> pulse_o == {SIG_PULSE1[slot_q], SIG_PULSE0[slot_q]})
    else $error("pulse lines do not follow their signatures");

endmodule // sid_sig_gen
